// File: core/wdw_defs.vh
// constants for the watchdog and wakeup timer block
`ifndef WDW_DEFS_VH
`define WDW_DEFS_VH
`define WDW_ADDR_DATA_HIGH  8'hab
`define WDW_ADDR_DATA_LOW   8'hac
`define WDW_ADDR_CONTROL    8'had
`define WDW_ADDR_TICK_DIV   8'hb5
`define WDW_RST_TICK_DIV    8'h03
`define WDW_RST_DATA        8'h00
`define WDW_CTL_ADDR_LSB    0
`define WDW_CTL_ADDR_MSB    2
`define WDW_CTL_WRITE_BIT   3
`define WDW_CTL_BUSY_BIT    4
`define WDW_IA_WATCHDOG     3'h0
`define WDW_IA_WAKE_HIGH    3'h1
`define WDW_IA_WAKE_LOW     3'h2
`define WDW_IA_WAKE_COUNT   3'h3
`define WDW_IA_STATUS_CFG0  3'h4
`define WDW_IA_STATUS_CFG1  3'h5
`define WDW_DEB_CNT_01      7'h02
`define WDW_DEB_CNT_10      7'h08
`define WDW_DEB_CNT_11      7'h40
`define WDW_EDGE_DELAY      2
`define WDW_STATUS_TIMER    8
`endif

// File: core/wdw_timer.v
// watchdog, tick divider, wakeup timer and port 0 pin wakeup logic
`timescale 1ns/10ps
`include "wdw_defs.vh"
module wdw_timer (
   input  wire        i_clk,
   input  wire        i_reset_n,
   input  wire        i_clk_en,
   input  wire        i_sfr_wr,
   input  wire        i_sfr_rd,
   input  wire [7:0]  i_sfr_addr,
   input  wire [7:0]  i_sfr_wdata,
   output reg  [7:0]  o_sfr_rdata,
   input  wire        i_wakeup_irq_en,
   input  wire [5:0]  i_port0_pins,
   output reg         o_wakeup_irq,
   output reg         o_wake_exit,
   output reg         o_wake_reload_pin,
   output reg         o_watchdog_active,
   output reg         o_system_reset
);

   // indirect map behind the control register, bits 2:0 of a control write
   //   0: watchdog count, read and load
   //   1: read gives counter and latch upper bytes; write loads latch upper
   //      byte from the low data byte and the reload-pin nibble from the high
   //   2: lower latch half; a write also reloads and enables the timer
   //   3: read gives the live counter; a write disables the timer
   //   4: read gives and clears wake status; write sets pins 0 to 3 config
   //   5: same status read; write sets pins 4 and 5 config
   //   6, 7: reserved, reads give zero and writes do nothing
   // bit 3 picks write (1) or read (0); bit 4 reads as the busy flag
   //
   // timing of a command, one slow cycle each:
   //   edge with the control write: command takes effect, busy set
   //   next edge: busy drops, results already in the data pair
   // firmware that polls busy therefore never sees more than one busy read
   //
   // limitation: the upper latch byte is not guarded in hardware; writing it
   // while the timer runs shifts the next reload, so software must stop first
   //
   // limitation: the system reset output is a request only; the chip-level
   // reset must come back in on i_reset_n to clear this block

   // debounce length for a code, used by every pin
   function [6:0] deb_len;
      input [1:0] code;
      begin
         case (code)
            2'b01:   deb_len = `WDW_DEB_CNT_01;
            2'b10:   deb_len = `WDW_DEB_CNT_10;
            2'b11:   deb_len = `WDW_DEB_CNT_11;
            default: deb_len = 7'h00;
         endcase
      end
   endfunction

   // register state
   reg  [7:0]  tick_divider_q;
   reg  [7:0]  data_high_q;
   reg  [7:0]  data_low_q;
   reg  [3:0]  control_q;
   reg         busy_q;
   reg  [7:0]  tick_cnt_q;
   reg  [15:0] wd_count_q;
   reg  [23:0] wake_latch_q;
   reg  [23:0] wake_count_q;
   reg         wake_en_q;
   reg         timer_flag_q;
   reg  [5:0]  pin_flag_q;
   reg  [15:0] cfg0_q;
   reg  [7:0]  cfg1_q;
   reg  [3:0]  gp_latch_q;
   wire        tick;
   wire [15:0] wdata;
   wire [23:0] cfg_all;
   wire [5:0]  pin_event;
   wire        wake_expire;

   // config layout per pin in cfg_all: [4g+1:4g] debounce, [4g+3:4g+2] edge;
   // pins 0 to 3 come from the first config word, pins 4 and 5 from the
   // low byte of the second, matching the write layout of the indirect map
   // gp_latch_q holds the reload-pin nibble; this block drives one reload
   // pin only, so the nibble is stored but not decoded here

   // the whole block already runs on the slow clock, so a command completes
   // in one cycle; busy covers that cycle so polling firmware stays portable
   // the tick compare is "at or above" rather than "equal": lowering the
   // divider while the count sits above it would otherwise let the count
   // wrap through 255 and stretch one tick to over two hundred cycles
   assign tick  = (tick_cnt_q >= tick_divider_q);
   assign wdata = {data_high_q, data_low_q};
   assign cfg_all = {cfg1_q, cfg0_q};
   assign wake_expire = tick && wake_en_q && (wake_count_q == 24'h000000);

   // reads are combinational: data is valid in the cycle the address is
   // presented, and reading has no side effect; clearing status happens
   // only through the indirect read command, never through a plain read
   // read mux of direct registers; indirect results land in the data pair
   always @* begin
      case (i_sfr_addr)
         `WDW_ADDR_DATA_HIGH: o_sfr_rdata = data_high_q;
         `WDW_ADDR_DATA_LOW:  o_sfr_rdata = data_low_q;
         `WDW_ADDR_CONTROL:   o_sfr_rdata = {3'b000, busy_q, control_q};
         `WDW_ADDR_TICK_DIV:  o_sfr_rdata = tick_divider_q;
         default:             o_sfr_rdata = 8'h00;
      endcase
   end

   // the divider resets to three so the tick runs at four cycles before
   // firmware touches anything
   // tick divider, clocked by the always-running slow clock
   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         tick_cnt_q     <= 8'h00;
         tick_divider_q <= `WDW_RST_TICK_DIV;
      end else if (i_clk_en) begin
         tick_cnt_q <= tick ? 8'h00 : tick_cnt_q + 8'h01;
         if (i_sfr_wr && i_sfr_addr == `WDW_ADDR_TICK_DIV)
            tick_divider_q <= i_sfr_wdata;
      end
   end

   // pin filters and edge detectors, one instance of logic per pin
   genvar g;
   generate
      for (g = 0; g < 6; g = g + 1) begin : pin
         reg  [6:0] stab_q;
         reg        filt_q;
         reg        filt_old_q;
         reg  [1:0] dly_q;
         wire [1:0] deb_code  = cfg_all[4*g+1:4*g];
         wire [1:0] edge_code = cfg_all[4*g+3:4*g+2];
         wire       rise = filt_q & ~filt_old_q;
         wire       fall = ~filt_q & filt_old_q;
         // filter: stab_q counts cycles the pin has disagreed with filt_q;
         // any agreement restarts it, so a glitch shorter than the chosen
         // length never reaches the edge detector
         // code 00 still costs one cycle, the price of a registered filter
         // edge detect compares the filter with its one-cycle-old copy
         // filter and old copy both reset low, so a pin held low is quiet
         // level passes only after staying stable for the chosen count
         always @(posedge i_clk) begin
            if (!i_reset_n) begin
               stab_q     <= 7'h00;
               filt_q     <= 1'b0;
               filt_old_q <= 1'b0;
               dly_q      <= 2'b00;
            end else if (i_clk_en) begin
               if (i_port0_pins[g] == filt_q)
                  stab_q <= 7'h00;
               else if (stab_q >= deb_len(deb_code)) begin
                  filt_q <= i_port0_pins[g];
                  stab_q <= 7'h00;
               end else
                  stab_q <= stab_q + 7'h01;
               filt_old_q <= filt_q;
               // two-stage delay from filtered edge to indication
               dly_q <= {dly_q[0], (rise & edge_code[0]) | (fall & edge_code[1])};
            end
         end
         assign pin_event[g] = dly_q[1];
      end
   endgenerate

   // one process owns every register that a command can touch, so a
   // command and a timer or watchdog event in the same cycle resolve by
   // statement order here rather than across processes:
   //   - timer reload before a latch write, so the write wins
   //   - status clear loads the flags from that cycle's events, so the event survives
   //   - watchdog decrement before a load, so the load wins
   // indirect command engine, wakeup timer and watchdog
   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         data_high_q       <= `WDW_RST_DATA;
         data_low_q        <= `WDW_RST_DATA;
         control_q         <= 4'h0;
         busy_q            <= 1'b0;
         wd_count_q        <= 16'h0000;
         o_watchdog_active <= 1'b0;
         o_system_reset    <= 1'b0;
         wake_latch_q      <= 24'h000000;
         wake_count_q      <= 24'h000000;
         wake_en_q         <= 1'b0;
         timer_flag_q      <= 1'b0;
         pin_flag_q        <= 6'h00;
         cfg0_q            <= 16'h0000;
         cfg1_q            <= 8'h00;
         gp_latch_q        <= 4'h0;
         o_wakeup_irq      <= 1'b0;
         o_wake_exit       <= 1'b0;
         o_wake_reload_pin <= 1'b0;
      end else if (i_clk_en) begin
         busy_q            <= 1'b0;
         o_wake_exit       <= 1'b0;
         o_wake_reload_pin <= 1'b0;
         o_system_reset    <= 1'b0;
         o_wakeup_irq      <= 1'b0;
         if (i_sfr_wr && i_sfr_addr == `WDW_ADDR_DATA_HIGH)
            data_high_q <= i_sfr_wdata;
         if (i_sfr_wr && i_sfr_addr == `WDW_ADDR_DATA_LOW)
            data_low_q <= i_sfr_wdata;
         // wakeup timer counts ticks and reloads itself at zero
         if (tick && wake_en_q) begin
            if (wake_count_q == 24'h000000)
               wake_count_q <= wake_latch_q;
            else
               wake_count_q <= wake_count_q - 24'h000001;
         end
         // the watchdog keeps pulsing reset on every tick while at zero, so a
         // chip reset that is slow to act still sees a request; the block
         // itself does not clear the count, only the system reset does
         // watchdog counts ticks once armed
         if (o_watchdog_active && tick) begin
            if (wd_count_q == 16'h0000)
               o_system_reset <= 1'b1;
            else
               wd_count_q <= wd_count_q - 16'h0001;
         end
         // status read hands the flags over and clears them in one step; an
         // event in that same cycle is kept for the next read rather than lost
         // pending events; a new event wins over the read clear below
         if (wake_expire) begin
            timer_flag_q      <= 1'b1;
            o_wakeup_irq      <= i_wakeup_irq_en;
            o_wake_exit       <= 1'b1;
            o_wake_reload_pin <= 1'b1;
         end
         if (|pin_event)
            o_wake_exit <= 1'b1;
         // control write runs the addressed command
         if (i_sfr_wr && i_sfr_addr == `WDW_ADDR_CONTROL) begin
            control_q <= i_sfr_wdata[3:0];
            busy_q    <= 1'b1;
            o_watchdog_active <= 1'b1;
            if (i_sfr_wdata[`WDW_CTL_WRITE_BIT]) begin
               case (i_sfr_wdata[2:0])
                  `WDW_IA_WATCHDOG:   wd_count_q <= wdata;
                  // firmware keeps this to times the timer is off
                  `WDW_IA_WAKE_HIGH: begin
                     wake_latch_q[23:16] <= data_low_q;
                     gp_latch_q          <= data_high_q[3:0];
                  end
                  `WDW_IA_WAKE_LOW: begin
                     wake_latch_q[15:0] <= wdata;
                     wake_count_q <= {wake_latch_q[23:16], wdata};
                     wake_en_q    <= 1'b1;
                  end
                  `WDW_IA_WAKE_COUNT: wake_en_q <= 1'b0;
                  `WDW_IA_STATUS_CFG0: cfg0_q <= wdata;
                  `WDW_IA_STATUS_CFG1: cfg1_q <= wdata[7:0];
                  default: ;
               endcase
            end else begin
               case (i_sfr_wdata[2:0])
                  `WDW_IA_WATCHDOG: {data_high_q, data_low_q} <= wd_count_q;
                  `WDW_IA_WAKE_HIGH: begin
                     data_high_q <= wake_count_q[23:16];
                     data_low_q  <= wake_latch_q[23:16];
                  end
                  `WDW_IA_WAKE_LOW:   {data_high_q, data_low_q} <= wake_latch_q[15:0];
                  `WDW_IA_WAKE_COUNT: {data_high_q, data_low_q} <= wake_count_q[15:0];
                  `WDW_IA_STATUS_CFG0, `WDW_IA_STATUS_CFG1: begin
                     data_high_q <= {7'h00, timer_flag_q};
                     data_low_q  <= {2'b00, pin_flag_q};
                     timer_flag_q <= wake_expire;
                     pin_flag_q   <= pin_event;
                  end
                  default: {data_high_q, data_low_q} <= 16'h0000;
               endcase
            end
         end
         if (|pin_event && !(i_sfr_wr && i_sfr_addr == `WDW_ADDR_CONTROL &&
             !i_sfr_wdata[3] && i_sfr_wdata[2:1] == 2'b10))
            pin_flag_q <= pin_flag_q | pin_event;
      end
   end

endmodule

// File: verification/wdw_timer_props.sv
// concurrent checks on the ports of the watchdog and wakeup timer
`timescale 1ns/10ps
module wdw_timer_props (
   input wire       i_clk,
   input wire       i_reset_n,
   input wire       i_clk_en,
   input wire       i_sfr_wr,
   input wire [7:0] i_sfr_addr,
   input wire [7:0] i_sfr_wdata,
   input wire [7:0] o_sfr_rdata,
   input wire       i_wakeup_irq_en,
   input wire       o_wakeup_irq,
   input wire       o_wake_exit,
   input wire       o_watchdog_active,
   input wire       o_system_reset
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   wire       wr_ok  = i_sfr_wr && i_clk_en;
   wire       ctl_wr = wr_ok && i_sfr_addr == 8'had;
   reg  [7:0] div_q;
   // shadow of the divider, so every read of it is judged, not only the next one
   always @(posedge i_clk) begin
      if (!i_reset_n) div_q <= 8'h03;
      else if (wr_ok && i_sfr_addr == 8'hb5) div_q <= i_sfr_wdata;
   end
   irq_exit_a: assert property (o_wakeup_irq |-> o_wake_exit)
      else $error("interrupt pulse without wake exit");
   irq_gate_a: assert property (o_wakeup_irq |-> $past(i_wakeup_irq_en))
      else $error("interrupt while disabled");
   wd_arm_a: assert property (ctl_wr |=> o_watchdog_active)
      else $error("control write left watchdog idle");
   wd_sticky_a: assert property (o_watchdog_active |=> o_watchdog_active)
      else $error("watchdog dropped without reset");
   reset_cause_a: assert property (o_system_reset |-> o_watchdog_active)
      else $error("system reset from idle watchdog");
   busy_flag_a: assert property (ctl_wr |=> i_sfr_addr != 8'had || o_sfr_rdata[4])
      else $error("busy flag clear after control write");
   div_read_a: assert property (i_sfr_addr == 8'hb5 |-> o_sfr_rdata == div_q)
      else $error("divider read mismatch");
   ctl_spare_a: assert property (i_sfr_addr == 8'had |-> o_sfr_rdata[7:5] == 3'h0)
      else $error("unused control bits set");
   unmapped_a: assert property (!(i_sfr_addr inside {8'hab, 8'hac, 8'had, 8'hb5})
      |-> o_sfr_rdata == 8'h00)
      else $error("unmapped address reads nonzero");
endmodule

// File: verification/tb.sv
// self-checking bench for the watchdog and wakeup timer
`timescale 1ns/10ps
module tb;
   reg        i_clk = 1'b0, i_reset_n = 1'b0, irq_en = 1'b0, wr = 1'b0;
   reg  [7:0] addr = 8'h00, wd = 8'h00;
   reg  [5:0] pins = 6'h00;
   wire [7:0] rd;
   wire       irq, wexit, rld, wact, srst;
   integer    err_total = 0, compares = 0, cyc = 0, seed = 28, n, t, g, ni, k, a, b;
   always #4 i_clk = ~i_clk;
   wdw_timer DUT (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_clk_en(1'b1), .i_sfr_wr(wr),
      .i_sfr_rd(1'b0), .i_sfr_addr(addr), .i_sfr_wdata(wd), .o_sfr_rdata(rd),
      .i_wakeup_irq_en(irq_en), .i_port0_pins(pins), .o_wakeup_irq(irq),
      .o_wake_exit(wexit), .o_wake_reload_pin(rld), .o_watchdog_active(wact),
      .o_system_reset(srst));
   function integer xs(input integer s);
      reg [31:0] x;
      x = s;
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task ck(input ok, input [127:0] m);
      compares = compares + 1;
      if (ok !== 1'b1) begin
         err_total = err_total + 1;
         $display("ERROR %0t %0s", $time, m);
      end
   endtask
   // one idle cycle between writes keeps every strobe edge distinct
   task wr1(input [7:0] ad, input [7:0] d);
      @(posedge i_clk);
      addr <= ad; wd <= d; wr <= 1'b1;
      @(posedge i_clk);
      wr <= 1'b0;
   endtask
   task rdv(input [7:0] ad);
      @(posedge i_clk);
      addr <= ad;
      @(negedge i_clk);
   endtask
   task ind_w(input [2:0] ia, input [7:0] hi, input [7:0] lo);
      wr1(8'hab, hi); wr1(8'hac, lo); wr1(8'had, {5'h01, ia});
   endtask
   // counts cycles until the next reload pulse, plus interrupts seen meanwhile
   task gap;
      g = 0; ni = 0;
      do begin
         @(negedge i_clk);
         g = g + 1;
         ni = ni + (irq === 1'b1);
      end while (rld !== 1'b1 && g < 2000);
   endtask
   task pin(input v);
      @(posedge i_clk);
      pins <= {5'h00, v};
      b = 0;
      repeat (12) begin
         @(negedge i_clk);
         b = b + (wexit === 1'b1);
      end
   endtask
   task report_and_stop;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_total = err_total + 1;
         report_and_stop;
      end
   end
   initial begin
      repeat (3) @(posedge i_clk);
      i_reset_n <= 1'b1;
      rdv(8'hb5); ck(rd === 8'h03, "divider reset");
      rdv(8'h07); ck(rd === 8'h00, "unmapped read");
      for (k = 0; k < 2; k = k + 1) begin
         seed = xs(seed);
         n = (seed & 7) + 1;
         t = ((seed >> 4) & 3) + 1;
         irq_en <= k[0];
         wr1(8'hb5, t - 1);
         ind_w(3'h0, 8'h20, 8'h00);
         ind_w(3'h2, 8'h00, n);
         gap; ck(g >= n * t && g <= (n + 2) * t + 3, "first wake");
         gap; ck(g === (n + 1) * t, "wake period");
         ck(ni === k, "irq gating");
         wr1(8'had, 8'h02); rdv(8'hac); ck(rd === n, "latch read");
         ind_w(3'h3, 8'h00, 8'h00);
         ind_w(3'h1, 8'h00, k);
         wr1(8'had, 8'h01); rdv(8'hac); ck(rd === k, "high latch");
         wr1(8'had, 8'h04); rdv(8'hab); ck(rd[0] === 1'b1, "timer flag");
         wr1(8'had, 8'h04); rdv(8'hab); ck(rd[0] === 1'b0, "flag clears");
         gap; ck(g === 2000, "timer stopped");
         $display("timer pass %0d done", k);
      end
      // rising with the longest filter on a short pulse first, then the edge codes with no filter
      for (k = 0; k < 4; k = k + 1) begin
         a = (k == 0) ? 8'h07 : (k << 2);
         ind_w(3'h4, 8'h00, a);
         pin(1'b1); ck(b === ((k & 1) != 0), "rising wake");
         pin(1'b0); ck(b === (k > 1), "falling wake");
         wr1(8'had, 8'h04); rdv(8'hac); ck(rd[0] === (k != 0), "pin flag");
      end
      $display("pin wake done");
      wr1(8'hb5, 8'h00);
      ind_w(3'h0, 8'h00, 8'h10);
      g = 0;
      while (srst !== 1'b1 && g < 100) begin
         @(negedge i_clk);
         g = g + 1;
      end
      ck(g >= 15 && g <= 19, "watchdog expiry");
      ck(wact === 1'b1, "watchdog armed");
      @(posedge i_clk); i_reset_n <= 1'b0;
      @(posedge i_clk); i_reset_n <= 1'b1;
      @(negedge i_clk); ck(wact === 1'b0, "reset disarms");
      $display("watchdog done");
      report_and_stop;
   end
endmodule
bind wdw_timer wdw_timer_props CHK (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en),
   .i_sfr_wr(i_sfr_wr), .i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata),
   .o_sfr_rdata(o_sfr_rdata), .i_wakeup_irq_en(i_wakeup_irq_en), .o_wakeup_irq(o_wakeup_irq),
   .o_wake_exit(o_wake_exit), .o_watchdog_active(o_watchdog_active),
   .o_system_reset(o_system_reset));
